//--- pkg/comc_pkg.sv
// Constants for the operating-mode configuration block.
// Assumes a 40 MHz core clock and a two-wire management host on MDC/MDIO.
package comc_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ              = 40_000_000;
  localparam int unsigned RS232_MAX_BAUD      = 500_000;
  // Shortest serial bit the baud detector must resolve
  localparam int unsigned RS232_MIN_BIT_CYC   = CLK_HZ / RS232_MAX_BAUD;
  localparam int unsigned MODEM_LINES         = 6;
  // Register indices on the management interface
  localparam logic [4:0]  REG_PORT_IF         = 5'h0a;
  localparam logic [4:0]  REG_FWD_MODE        = 5'h0b;
  // Field positions, port interface register
  localparam int unsigned P1_TYPE_LSB         = 0;
  localparam int unsigned P2_TYPE_LSB         = 2;
  localparam int unsigned P1_EXT_BIT          = 4;
  localparam int unsigned P2_EXT_BIT          = 5;
  localparam int unsigned TWIN_PHY_BIT        = 8;
  localparam logic [15:0] PORT_IF_MASK        = 16'h013f;
  // Field positions, forwarding mode register
  localparam int unsigned CONV_BIT            = 0;
  localparam int unsigned EARLY_FWD_BIT       = 1;
  localparam int unsigned BYPASS_BIT          = 2;
  localparam logic [15:0] FWD_MODE_MASK       = 16'h0007;
  // Values held during reset, before the straps are caught
  localparam logic [15:0] PORT_IF_RESET       = 16'h000f;
  localparam logic [15:0] FWD_MODE_RESET      = 16'h0002;
  // Interface type codes
  localparam logic [1:0]  IF_RS232            = 2'b00;
  localparam logic [1:0]  IF_SMII             = 2'b01;
  localparam logic [1:0]  IF_REV_MII          = 2'b10;
  localparam logic [1:0]  IF_MII              = 2'b11;
  // Frame length limits in bytes
  localparam logic [13:0] LEN_SWITCH_MAX      = 14'd2046;
  localparam logic [13:0] LEN_JUMBO_MAX       = 14'd9216;
  // Management frame figures
  localparam logic [5:0]  PREAMBLE_ONES       = 6'd32;
  localparam logic [4:0]  HDR_LAST            = 5'd13;
  localparam logic [4:0]  DATA_LAST           = 5'd15;
  localparam logic [1:0]  OP_WRITE            = 2'b01;
  localparam logic [1:0]  OP_READ             = 2'b10;
  // Edges between reset release and strap capture
  localparam logic [1:0]  STRAP_WAIT          = 2'd2;
  // Strap vector positions
  localparam int unsigned S_BYPASS_DIS        = 0;
  localparam int unsigned S_EARLY_DIS         = 1;
  localparam int unsigned S_CONV_DIS          = 2;
  localparam int unsigned S_TWIN_DIS          = 3;
  localparam int unsigned S_P1_EXT_DIS        = 4;
  localparam int unsigned S_P2_EXT_DIS        = 5;
  localparam int unsigned S_P1_TYPE           = 6;
  localparam int unsigned S_P2_TYPE           = 8;
  localparam int unsigned STRAP_W             = 10;
endpackage

//--- rtl/comc_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no word coherence is given.
`timescale 1ns/1ps
module comc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // Refused at elaboration, an empty vector has nothing to carry
  if (W < 1)
  begin
    $error("comc_sync: W must be at least 1");
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

//--- rtl/comc_top.sv
// Mode configuration registers behind the two-wire management port,
// loaded from board straps at reset and decoded into mode outputs.
// Assumes MDC is at least eight core clocks per half period.
`timescale 1ns/1ps
//
// Contract
// - Forwarding register bit 2 set selects pure pass-through with no maintenance-frame processing.
// - Pass-through forwards every frame unchanged and ignores the converter and cut-through bits.
// - Converter and pass-through modes accept frames up to nine kilobytes.
// - Switch modes limit frames to 2046 bytes.
// - With bit 2 clear, codes 00 and 10 in bits 1:0 select switch operation.
// - With bit 2 clear, codes 01 and 11 in bits 1:0 select converter operation.
// - Port register bit 8 set enables dual-PHY operation with independent port interfaces.
// - Port register bits 5:4 enable the external interfaces of ports 1 and 2.
// - Port register bits 1:0 and 3:2 give the port types, 00 RS232 and 11 MII.
// - Type code 01 selects serial-reduced MII and 10 reversed MII.
// - A port with its external interface off ignores its type field.
// - With bit 2 clear, management accesses to another PHY address go to the remote peer as maintenance requests.
// - RS232 mode carries six modem lines for each of the two port pairs.
// - RS232 mode detects baud rates up to 500 kbit/s.
// - Straps are sampled at the end of reset and later writes override them.
module comc_top #(
  parameter logic [4:0] LOCAL_PHY_ADDR = 5'h00
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Management port
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Straps
  input  wire logic        bypass_forward_disable,
  input  wire logic        early_forward_disable,
  input  wire logic        converter_disable,
  input  wire logic        twin_phy_disable,
  input  wire logic        port1_external_if_disable,
  input  wire logic        port2_external_if_disable,
  input  wire logic [1:0]  port1_if_type_strap,
  input  wire logic [1:0]  port2_if_type_strap,
  // Decoded mode
  output logic             mode_switch,
  output logic             mode_converter,
  output logic             mode_bypass,
  output logic             early_forward_en,
  output logic             maint_frame_en,
  output logic             forward_all,
  output logic [13:0]      max_frame_len,
  output logic             twin_phy_en,
  output logic             port1_ext_en,
  output logic             port2_ext_en,
  output logic [1:0]       port1_if_type,
  output logic [1:0]       port2_if_type,
  output logic             port1_rs232_en,
  output logic             port2_rs232_en,
  output logic [7:0]       rs232_min_bit_cyc,
  // Remote access requests
  output logic             remote_req,
  output logic             remote_rd,
  output logic [4:0]       remote_phy,
  output logic [4:0]       remote_reg,
  output logic [15:0]      remote_wdata
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HDR  = 4'b0010,
    ST_TA   = 4'b0100,
    ST_DATA = 4'b1000
  } comc_state_e;

  typedef struct packed {
    comc_state_e st;
    logic [5:0]  ones;
    logic [4:0]  cnt;
    logic [15:0] sh;
    logic [12:0] hdr;
    logic        mdc_q;
    logic [1:0]  init_cnt;
    logic        init_done;
    logic [15:0] port_cfg;
    logic [15:0] fwd_cfg;
    logic        mdio_out;
    logic        mdio_oe;
    logic        mode_switch;
    logic        mode_converter;
    logic        mode_bypass;
    logic        early_forward_en;
    logic        maint_frame_en;
    logic        forward_all;
    logic [13:0] max_frame_len;
    logic        twin_phy_en;
    logic        port1_ext_en;
    logic        port2_ext_en;
    logic [1:0]  port1_if_type;
    logic [1:0]  port2_if_type;
    logic        port1_rs232_en;
    logic        port2_rs232_en;
    logic        remote_req;
    logic        remote_rd;
    logic [4:0]  remote_phy;
    logic [4:0]  remote_reg;
    logic [15:0] remote_wdata;
  } comc_regs_s;

  localparam int unsigned SW = comc_pkg::STRAP_W + 2;
  localparam comc_regs_s REG_RESET = '{
    st: ST_IDLE, port_cfg: comc_pkg::PORT_IF_RESET, fwd_cfg: comc_pkg::FWD_MODE_RESET,
    max_frame_len: comc_pkg::LEN_SWITCH_MAX, mode_switch: 1'b1, maint_frame_en: 1'b1,
    port1_if_type: comc_pkg::IF_MII, port2_if_type: comc_pkg::IF_MII, default: '0};

  logic [SW-1:0] pin_s;
  logic [9:0]    strap;
  logic          mdc_s;
  logic          mdio_s;
  comc_regs_s    r;
  comc_regs_s    next_r;

  // Pins are asynchronous to mclk
  comc_sync #(.W(SW)) comc_sync_i (
    .mclk (mclk),
    .rst  (rst),
    .din  ({mdio_in, mdc, port2_if_type_strap, port1_if_type_strap, port2_external_if_disable,
            port1_external_if_disable, twin_phy_disable, converter_disable, early_forward_disable,
            bypass_forward_disable}),
    .dout (pin_s)
  );
  assign strap  = pin_s[9:0];
  assign mdc_s  = pin_s[10];
  assign mdio_s = pin_s[11];

  always_comb
  begin
    logic        rise;
    logic [12:0] hdr_n;
    logic        local_hit;
    logic [15:0] rdata;
    rise      = mdc_s & ~r.mdc_q;
    hdr_n     = {r.hdr[11:0], mdio_s};
    local_hit = (r.hdr[9:5] == LOCAL_PHY_ADDR);
    rdata     = (r.hdr[4:0] == comc_pkg::REG_PORT_IF) ? r.port_cfg :
                (r.hdr[4:0] == comc_pkg::REG_FWD_MODE) ? r.fwd_cfg : 16'h0000;
    next_r            = r;
    next_r.mdc_q      = mdc_s;
    next_r.remote_req = 1'b0;
    // Straps caught once synchroniser has settled
    if (!r.init_done)
    begin
      next_r.init_cnt = r.init_cnt + 2'd1;
      if (r.init_cnt == comc_pkg::STRAP_WAIT)
      begin
        next_r.init_done = 1'b1;
        next_r.fwd_cfg   = {13'h0000, ~strap[comc_pkg::S_BYPASS_DIS],
                            ~strap[comc_pkg::S_EARLY_DIS], ~strap[comc_pkg::S_CONV_DIS]};
        next_r.port_cfg  = {7'h00, ~strap[comc_pkg::S_TWIN_DIS], 2'b00,
                            ~strap[comc_pkg::S_P2_EXT_DIS], ~strap[comc_pkg::S_P1_EXT_DIS],
                            strap[comc_pkg::S_P2_TYPE +: 2], strap[comc_pkg::S_P1_TYPE +: 2]};
      end
    end
    else if (rise)
    begin
      unique case (r.st)
        ST_IDLE:
        begin
          if (mdio_s)
            next_r.ones = (r.ones == comc_pkg::PREAMBLE_ONES) ? r.ones : r.ones + 6'd1;
          else if (r.ones == comc_pkg::PREAMBLE_ONES)
          begin
            next_r.st  = ST_HDR;
            next_r.cnt = 5'd1;
            next_r.hdr = '0;
          end
          else
            next_r.ones = '0;
        end
        ST_HDR:
        begin
          next_r.hdr = hdr_n;
          next_r.cnt = r.cnt + 5'd1;
          if (r.cnt == comc_pkg::HDR_LAST)
          begin
            next_r.ones = '0;
            next_r.cnt  = '0;
            if (hdr_n[12] && (hdr_n[11:10] == comc_pkg::OP_WRITE || hdr_n[11:10] == comc_pkg::OP_READ))
              next_r.st = ST_TA;
            else
              next_r.st = ST_IDLE;
          end
        end
        ST_TA:
        begin
          next_r.cnt = r.cnt + 5'd1;
          if (r.cnt == 5'd0)
          begin
            // Remote reads are answered by the peer, not here
            next_r.mdio_oe  = (r.hdr[11:10] == comc_pkg::OP_READ) && local_hit;
            next_r.mdio_out = 1'b0;
          end
          else
          begin
            next_r.st       = ST_DATA;
            next_r.cnt      = '0;
            next_r.sh       = rdata;
            next_r.mdio_out = rdata[15];
          end
        end
        ST_DATA:
        begin
          next_r.cnt = r.cnt + 5'd1;
          if (r.hdr[11:10] == comc_pkg::OP_READ)
          begin
            next_r.sh       = {r.sh[14:0], 1'b0};
            next_r.mdio_out = r.sh[14];
          end
          else
            next_r.sh = {r.sh[14:0], mdio_s};
          if (r.cnt == comc_pkg::DATA_LAST)
          begin
            next_r.st       = ST_IDLE;
            next_r.mdio_oe  = 1'b0;
            next_r.mdio_out = 1'b0;
            if (local_hit && r.hdr[11:10] == comc_pkg::OP_WRITE)
            begin
              // Writes override the strap values
              if (r.hdr[4:0] == comc_pkg::REG_PORT_IF)
                next_r.port_cfg = {r.sh[14:0], mdio_s} & comc_pkg::PORT_IF_MASK;
              if (r.hdr[4:0] == comc_pkg::REG_FWD_MODE)
                next_r.fwd_cfg = {r.sh[14:0], mdio_s} & comc_pkg::FWD_MODE_MASK;
            end
            else if (!local_hit && r.maint_frame_en)
            begin
              next_r.remote_req   = 1'b1;
              next_r.remote_rd    = (r.hdr[11:10] == comc_pkg::OP_READ);
              next_r.remote_phy   = r.hdr[9:5];
              next_r.remote_reg   = r.hdr[4:0];
              next_r.remote_wdata = {r.sh[14:0], mdio_s};
            end
          end
        end
      endcase
    end
    // Mode decode, one cycle behind the registers
    next_r.mode_bypass      = r.fwd_cfg[comc_pkg::BYPASS_BIT];
    next_r.maint_frame_en   = ~r.fwd_cfg[comc_pkg::BYPASS_BIT];
    next_r.forward_all      = r.fwd_cfg[comc_pkg::BYPASS_BIT];
    next_r.mode_converter   = ~r.fwd_cfg[comc_pkg::BYPASS_BIT] & r.fwd_cfg[comc_pkg::CONV_BIT];
    next_r.mode_switch      = ~r.fwd_cfg[comc_pkg::BYPASS_BIT] & ~r.fwd_cfg[comc_pkg::CONV_BIT];
    next_r.early_forward_en = next_r.mode_switch & r.fwd_cfg[comc_pkg::EARLY_FWD_BIT];
    next_r.max_frame_len    = next_r.mode_switch ? comc_pkg::LEN_SWITCH_MAX : comc_pkg::LEN_JUMBO_MAX;
    next_r.twin_phy_en      = r.port_cfg[comc_pkg::TWIN_PHY_BIT];
    next_r.port1_ext_en     = r.port_cfg[comc_pkg::P1_EXT_BIT];
    next_r.port2_ext_en     = r.port_cfg[comc_pkg::P2_EXT_BIT];
    // Disabled port falls back to internal MII
    next_r.port1_if_type    = next_r.port1_ext_en ? r.port_cfg[comc_pkg::P1_TYPE_LSB +: 2]
                                                  : comc_pkg::IF_MII;
    next_r.port2_if_type    = next_r.port2_ext_en ? r.port_cfg[comc_pkg::P2_TYPE_LSB +: 2]
                                                  : comc_pkg::IF_MII;
    next_r.port1_rs232_en   = next_r.port1_ext_en && r.port_cfg[1:0] == comc_pkg::IF_RS232;
    next_r.port2_rs232_en   = next_r.port2_ext_en && r.port_cfg[3:2] == comc_pkg::IF_RS232;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      r <= REG_RESET;
    else
      r <= next_r;
  end

  assign mdio_out          = r.mdio_out;
  assign mdio_oe           = r.mdio_oe;
  assign mode_switch       = r.mode_switch;
  assign mode_converter    = r.mode_converter;
  assign mode_bypass       = r.mode_bypass;
  assign early_forward_en  = r.early_forward_en;
  assign maint_frame_en    = r.maint_frame_en;
  assign forward_all       = r.forward_all;
  assign max_frame_len     = r.max_frame_len;
  assign twin_phy_en       = r.twin_phy_en;
  assign port1_ext_en      = r.port1_ext_en;
  assign port2_ext_en      = r.port2_ext_en;
  assign port1_if_type     = r.port1_if_type;
  assign port2_if_type     = r.port2_if_type;
  assign port1_rs232_en    = r.port1_rs232_en;
  assign port2_rs232_en    = r.port2_rs232_en;
  // Constant bit time for the baud detector, 6 modem lines per pair
  assign rs232_min_bit_cyc = 8'(comc_pkg::RS232_MIN_BIT_CYC);
  assign remote_req        = r.remote_req;
  assign remote_rd         = r.remote_rd;
  assign remote_phy        = r.remote_phy;
  assign remote_reg        = r.remote_reg;
  assign remote_wdata      = r.remote_wdata;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_BYPASS: assert property (r.fwd_cfg[2] |=> mode_bypass && !maint_frame_en)
    else $error("bypass bit did not select pass-through");
  AST_FWD_ALL: assert property (mode_bypass |-> forward_all && !mode_converter && !mode_switch && !early_forward_en)
    else $error("pass-through not exclusive");
  AST_JUMBO: assert property ((mode_bypass || mode_converter) |-> max_frame_len == 14'd9216)
    else $error("jumbo limit wrong");
  AST_SW_LEN: assert property (mode_switch |-> max_frame_len == 14'd2046)
    else $error("switch limit wrong");
  AST_SWITCH: assert property (!r.fwd_cfg[2] && !r.fwd_cfg[0] |=> mode_switch)
    else $error("switch mode not selected");
  AST_CONV: assert property (!r.fwd_cfg[2] && r.fwd_cfg[0] |=> mode_converter && !mode_switch)
    else $error("converter mode not selected");
  AST_TWIN: assert property (twin_phy_en == $past(r.port_cfg[8]))
    else $error("twin phy enable mismatch");
  AST_EXT: assert property ($past(r.port_cfg[5:4]) == 2'b11 |-> port1_ext_en && port2_ext_en)
    else $error("external interfaces not enabled");
  AST_TYPE: assert property (r.port_cfg[4] |=> port1_if_type == $past(r.port_cfg[1:0]))
    else $error("port 1 type not passed");
  AST_IGNORE: assert property (!r.port_cfg[5] |=> port2_if_type == 2'b11 && !port2_rs232_en)
    else $error("disabled port type not ignored");
  AST_STRAP: assert property ($rose(r.init_done) |-> r.fwd_cfg[2] == !$past(strap[0])
                              && r.port_cfg[8] == !$past(strap[3]))
    else $error("strap not loaded");
  AST_REMOTE: assert property (remote_req |-> remote_phy != LOCAL_PHY_ADDR ##1 !remote_req)
    else $error("remote request malformed");
endmodule

//--- verification/comc_host_model.sv
// Management host model: drives MDC and MDIO frames toward the mode block.
// Assumes the bench resolves MDIO with a pull-up and runs mclk at 40 MHz.
`timescale 1ns/1ps
module comc_host_model #(
  parameter int unsigned HALF_CYC = 10
) (
  // Clock
  input  wire logic mclk,
  // Management pins
  input  wire logic mdio_in,
  output logic      mdc,
  output logic      host_en,
  output logic      host_bit
);
  initial
  begin
    mdc      = 1'b0;
    host_en  = 1'b0;
    host_bit = 1'b1;
  end

  // One whole frame; MDC stands low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                      input logic [15:0] wdata, output logic [15:0] rdata);
    logic [63:0] frame;
    frame = {32'hffff_ffff, 2'b01, op, phy, regad, 2'b10, wdata};
    rdata = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      repeat (HALF_CYC) @(posedge mclk);
      #1;
      mdc      = 1'b0;
      // Released for turnaround and data of a read, so the device can answer
      host_en  = !(op == comc_pkg::OP_READ && i < 18);
      host_bit = frame[i];
      repeat (HALF_CYC) @(posedge mclk);
      #1;
      // Sampled just before the rise, while the answer bit still stands
      if (i < 16)
        rdata[i] = mdio_in;
      mdc = 1'b1;
    end
    repeat (HALF_CYC) @(posedge mclk);
    #1;
    mdc     = 1'b0;
    host_en = 1'b0;
  endtask
endmodule

//--- verification/converter_operating_mode_config_tb.sv
// Self-checking bench for the mode block: straps, register writes, readback, remote requests.
// Assumes the host model in comc_host_model and a pull-up on MDIO.
`timescale 1ns/1ps
module converter_operating_mode_config_tb;
  logic        mclk;
  logic        rst;
  logic        mdc;
  logic        mdio_in;
  logic        mdio_out;
  logic        mdio_oe;
  logic        host_en;
  logic        host_bit;
  logic [9:0]  strap;
  logic        mode_switch, mode_converter, mode_bypass, early_forward_en, maint_frame_en, forward_all;
  logic        twin_phy_en, port1_ext_en, port2_ext_en, port1_rs232_en, port2_rs232_en;
  logic        remote_req, remote_rd;
  logic [13:0] max_frame_len;
  logic [1:0]  port1_if_type, port2_if_type;
  logic [7:0]  rs232_min_bit_cyc;
  logic [4:0]  remote_phy, remote_reg;
  logic [15:0] remote_wdata;
  logic [26:0] rem_seen = 27'h000_0000;
  int          rem_cnt  = 0;
  int          mismatches;
  int          checks_done;

  // Pull-up wins when nobody drives the line
  assign mdio_in = mdio_oe ? mdio_out : (host_en ? host_bit : 1'b1);

  comc_top #(.LOCAL_PHY_ADDR(5'h00)) comc_top_i (
    .mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .bypass_forward_disable(strap[comc_pkg::S_BYPASS_DIS]), .early_forward_disable(strap[comc_pkg::S_EARLY_DIS]),
    .converter_disable(strap[comc_pkg::S_CONV_DIS]), .twin_phy_disable(strap[comc_pkg::S_TWIN_DIS]),
    .port1_external_if_disable(strap[comc_pkg::S_P1_EXT_DIS]),
    .port2_external_if_disable(strap[comc_pkg::S_P2_EXT_DIS]),
    .port1_if_type_strap(strap[7:6]), .port2_if_type_strap(strap[9:8]),
    .mode_switch(mode_switch), .mode_converter(mode_converter), .mode_bypass(mode_bypass),
    .early_forward_en(early_forward_en), .maint_frame_en(maint_frame_en), .forward_all(forward_all),
    .max_frame_len(max_frame_len), .twin_phy_en(twin_phy_en), .port1_ext_en(port1_ext_en),
    .port2_ext_en(port2_ext_en), .port1_if_type(port1_if_type), .port2_if_type(port2_if_type),
    .port1_rs232_en(port1_rs232_en), .port2_rs232_en(port2_rs232_en), .rs232_min_bit_cyc(rs232_min_bit_cyc),
    .remote_req(remote_req), .remote_rd(remote_rd), .remote_phy(remote_phy), .remote_reg(remote_reg),
    .remote_wdata(remote_wdata));

  comc_host_model comc_host_model_i (.mclk(mclk), .mdio_in(mdio_in), .mdc(mdc), .host_en(host_en),
                                     .host_bit(host_bit));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (remote_req === 1'b1)
    begin
      rem_cnt  <= rem_cnt + 1;
      rem_seen <= {remote_rd, remote_phy, remote_reg, remote_wdata};
    end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Straps settle before release; first frame waits past strap capture
  task automatic do_reset(input logic [9:0] s);
    strap = s;
    rst   = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [4:0] regad, input logic [15:0] d);
    logic [15:0] unused_rd;
    comc_host_model_i.xfer(comc_pkg::OP_WRITE, 5'h00, regad, d, unused_rd);
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [4:0] regad, output logic [15:0] d);
    comc_host_model_i.xfer(comc_pkg::OP_READ, 5'h00, regad, 16'h0000, d);
  endtask

  task automatic test_defaults();
    logic [15:0] d;
    chk({mode_switch, mode_converter, mode_bypass, early_forward_en, maint_frame_en, forward_all}, 6'b100110);
    chk(max_frame_len, 14'h07fe);
    chk({twin_phy_en, port1_ext_en, port2_ext_en, port1_if_type, port2_if_type}, 7'b000_1111);
    chk(rs232_min_bit_cyc, 8'h50);
    rd(comc_pkg::REG_FWD_MODE, d);
    chk(d, 16'h0002);
    rd(comc_pkg::REG_PORT_IF, d);
    chk(d, 16'h000f);
  endtask

  task automatic test_fwd_codes();
    logic [2:0] c;
    logic       sw;
    for (int k = 0; k < 8; k++)
    begin
      c = k[2:0];
      wr(comc_pkg::REG_FWD_MODE, {13'h0000, c});
      sw = !c[2] && !c[0];
      chk({mode_switch, mode_converter, mode_bypass, early_forward_en, maint_frame_en, forward_all},
          {sw, !c[2] && c[0], c[2], sw && c[1], !c[2], c[2]});
      chk(max_frame_len, sw ? 14'h07fe : comc_pkg::LEN_JUMBO_MAX);
    end
  endtask

  task automatic test_port_types();
    logic [1:0]  c;
    logic [15:0] d;
    for (int k = 0; k < 4; k++)
    begin
      c = k[1:0];
      wr(comc_pkg::REG_PORT_IF, {8'h01, 2'b00, 2'b11, ~c, c});
      chk({twin_phy_en, port1_ext_en, port2_ext_en, port1_if_type, port2_if_type, port1_rs232_en, port2_rs232_en},
          {3'b111, c, ~c, c == 2'b00, c == 2'b11});
    end
    // Unwritable bits are dropped and both disabled interfaces fall back to MII
    wr(comc_pkg::REG_PORT_IF, 16'hfecc);
    chk({twin_phy_en, port1_ext_en, port2_ext_en, port1_if_type, port2_if_type, port1_rs232_en, port2_rs232_en},
        9'b000_11_11_00);
    rd(comc_pkg::REG_PORT_IF, d);
    chk(d, 16'h000c);
    wr(comc_pkg::REG_PORT_IF, 16'h0010);
    chk({twin_phy_en, port1_ext_en, port2_ext_en, port1_if_type, port2_if_type, port1_rs232_en, port2_rs232_en},
        9'b010_00_11_10);
  endtask

  task automatic test_remote();
    logic [15:0] d;
    int          n;
    // Leave pass-through, else maintenance requests are never carried
    wr(comc_pkg::REG_FWD_MODE, 16'h0001);
    n = rem_cnt;
    comc_host_model_i.xfer(comc_pkg::OP_WRITE, 5'h03, 5'h04, 16'ha5c3, d);
    chk(rem_cnt - n, 1);
    chk(rem_seen, {1'b0, 5'h03, 5'h04, 16'ha5c3});
    comc_host_model_i.xfer(comc_pkg::OP_READ, 5'h1f, 5'h0a, 16'h0000, d);
    chk(rem_cnt - n, 2);
    chk(rem_seen[26:16], {1'b1, 5'h1f, 5'h0a});
    // Unmapped local register reads as zero
    rd(5'h05, d);
    chk(d, 16'h0000);
    // Bad opcode is dropped, register keeps its value
    comc_host_model_i.xfer(2'b00, 5'h00, comc_pkg::REG_FWD_MODE, 16'h0004, d);
    rd(comc_pkg::REG_FWD_MODE, d);
    chk(d, 16'h0001);
  endtask

  // Second reset mid-run: straps must win over earlier writes
  task automatic test_alt_straps();
    logic [15:0] d;
    int          n;
    do_reset(10'h102);
    chk({mode_switch, mode_converter, mode_bypass, early_forward_en, maint_frame_en, forward_all}, 6'b001001);
    chk(max_frame_len, comc_pkg::LEN_JUMBO_MAX);
    chk({twin_phy_en, port1_ext_en, port2_ext_en, port1_if_type, port2_if_type, port1_rs232_en, port2_rs232_en},
        9'b111_00_01_10);
    rd(comc_pkg::REG_FWD_MODE, d);
    chk(d, 16'h0005);
    rd(comc_pkg::REG_PORT_IF, d);
    chk(d, 16'h0134);
    n = rem_cnt;
    comc_host_model_i.xfer(comc_pkg::OP_WRITE, 5'h03, 5'h04, 16'h1234, d);
    chk(rem_cnt - n, 0);
  endtask

  initial
  begin
    rst         = 1'b1;
    strap       = 10'h3fd;
    mismatches  = 0;
    checks_done = 0;
    do_reset(10'h3fd);
    test_defaults();
    test_fwd_codes();
    test_port_types();
    test_remote();
    test_alt_straps();
    complete_run();
  end

  // About 26 frames of 1300 clocks each fit well inside this span
  initial
  begin
    #2_000_000;
    mismatches++;
    complete_run();
  end
endmodule
